// *** instruction_field_decoder.v ***
/*
  instruction field decoder: takes instruction bytes one per clock from the
  fetch stage, gathers prefixes, opcode and addressing bytes, counts off the displacement and
  immediate bytes without keeping them, then holds the decoded fields until the next instruction, with a one-cycle valid pulse. software reaches
  default sizes and counters over an avalon-mm slave with waitrequest.
  assumes the byte stream comes from logic on i_core_clk and that the
  execution stage pulses i_exec_done when a locked instruction finishes.

*/
// Local design decisions: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "instruction_field_decoder_defines.vh"

module instruction_field_decoder (
  // clock and reset
  input wire i_core_clk,
  input wire i_rst_n,
  // instruction byte stream
  input wire i_byte_valid,
  input wire [7:0] i_byte_data,
  output wire o_byte_ready,
  // execution stage
  input wire i_exec_done,
  output wire o_bus_lock,
  // decoded instruction
  output wire o_dec_valid,
  output wire o_gp_fault,
  output wire [3:0] o_dec_len,
  output wire [7:0] o_opcode,
  output wire o_two_byte,
  output wire [2:0] o_group_sel,
  output wire [1:0] o_op_size,
  output wire o_addr32,
  output wire o_dir,
  output wire [3:0] o_reg_sel,
  output wire o_rm_is_reg,
  output wire [3:0] o_rm_sel,
  output wire o_mem_operand,
  output wire [3:0] o_base_sel,
  output wire [3:0] o_index_sel,
  output wire [1:0] o_scale,
  output wire [2:0] o_seg,
  output wire [2:0] o_disp_size,
  output wire [2:0] o_imm_size,
  output wire o_imm_sext,
  output wire o_repeat_while_unequal_prefix,
  output wire o_repeat_while_equal_prefix,
  output wire [2:0] o_sreg_sel,
  output wire o_sreg_valid,
  output wire [1:0] o_special_kind,
  output wire [2:0] o_special_sel,
  output wire o_special_valid,
  // avalon-mm slave
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output wire [31:0] o_avs_readdata,
  output wire o_avs_waitrequest
);

  localparam [5:0] ST_PFX = 6'h01;
  localparam [5:0] ST_OP2 = 6'h02;
  localparam [5:0] ST_MODRM = 6'h04;
  localparam [5:0] ST_SIB = 6'h08;
  localparam [5:0] ST_TAIL = 6'h10;
  localparam [5:0] ST_EMIT = 6'h20;

  // opcode attributes: [0] modrm [1] imm [2] has w [3] w [4] has d
  // [5] s [6] string [7] 2-bit segment [8] 3-bit segment [9] special move
  function [9:0] op_info;
    input two;
    input [7:0] op;
    begin
      op_info = 10'h000;
      if (two) begin
        op_info[0] = 1'b1;
        if (op[7:3] == 5'h04 && op[2:0] != 3'h5 && op[2:0] != 3'h7) begin
          op_info[9] = 1'b1;
          op_info[4] = 1'b1;
        end
      end else if (op[7:6] == 2'h0 && op[2] == 1'b0) begin
        op_info[0] = 1'b1;
        op_info[2] = 1'b1;
        op_info[3] = op[0];
        op_info[4] = 1'b1;
      end else if (op[7:6] == 2'h0 && op[2:1] == 2'h2) begin
        op_info[1] = 1'b1;
        op_info[2] = 1'b1;
        op_info[3] = op[0];
      end else if (op[7:5] == 3'h0 && op[2:1] == 2'h3) begin
        op_info[7] = 1'b1;
      end else if (op[7:2] == 6'h20) begin
        op_info[0] = 1'b1;
        op_info[1] = 1'b1;
        op_info[2] = 1'b1;
        op_info[3] = op[0];
        op_info[5] = op[1];
      end else if (op[7:2] == 6'h21 || op[7:2] == 6'h22) begin
        op_info[0] = 1'b1;
        op_info[2] = 1'b1;
        op_info[3] = op[0];
        op_info[4] = op[3];
      end else if (op == 8'h8C || op == 8'h8E) begin
        op_info[0] = 1'b1;
        op_info[8] = 1'b1;
      end else if (op[7:2] == 6'h29 || (op[7:4] == 4'hA && op[3:1] >= 3'h5)) begin
        op_info[2] = 1'b1;
        op_info[3] = op[0];
        op_info[6] = 1'b1;
      end else if (op[7:4] == 4'hB) begin
        op_info[1] = 1'b1;
        op_info[2] = 1'b1;
        op_info[3] = op[3];
      end else if (op[7:1] == 7'h63) begin
        op_info[0] = 1'b1;
        op_info[1] = 1'b1;
        op_info[2] = 1'b1;
        op_info[3] = op[0];
      end
    end
  endfunction

  function [3:0] imm_bytes;
    input [9:0] info;
    input opsz32;
    begin
      if (!info[1])
        imm_bytes = 4'h0;
      else if ((info[2] && !info[3]) || info[5])
        imm_bytes = 4'h1;
      else
        imm_bytes = opsz32 ? 4'h4 : 4'h2;
    end
  endfunction

  function [3:0] disp_bytes;
    input ad32;
    input [7:0] modrm;
    input [2:0] sib_base;
    begin
      if (modrm[7:6] == 2'h1)
        disp_bytes = 4'h1;
      else if (modrm[7:6] == 2'h2)
        disp_bytes = ad32 ? 4'h4 : 4'h2;
      else if (modrm[7:6] == 2'h3)
        disp_bytes = 4'h0;
      else if (!ad32)
        disp_bytes = (modrm[2:0] == 3'h6) ? 4'h2 : 4'h0;
      else if (modrm[2:0] == 3'h5 || (modrm[2:0] == 3'h4 && sib_base == 3'h5))
        disp_bytes = 4'h4;
      else
        disp_bytes = 4'h0;
    end
  endfunction

  // control and status
  reg [1:0] ctrl_r;
  reg [15:0] instr_cnt_r;
  reg [7:0] fault_cnt_r;
  reg wait_r;
  reg [31:0] rdata_r;

  // sequencing
  reg [5:0] state_r, state_nxt;
  reg ready_r;
  reg [4:0] len_r, len_nxt;
  reg [3:0] tail_r, tail_nxt;
  reg [3:0] imm_r, imm_nxt;
  reg [7:0] opcode_r, opcode_nxt;
  reg two_r, two_nxt;
  reg [7:0] modrm_r, modrm_nxt;
  reg [7:0] sib_r, sib_nxt;
  reg has_sib_r, has_sib_nxt;
  reg [2:0] pfx_seg_r, pfx_seg_nxt;
  reg pfx_ov_r, pfx_ov_nxt;
  reg pfx_opsz_r, pfx_opsz_nxt;
  reg pfx_adsz_r, pfx_adsz_nxt;
  reg pfx_lock_r, pfx_lock_nxt;
  reg pfx_repeat_while_unequal_prefix_r, pfx_repeat_while_unequal_prefix_nxt;
  reg pfx_repe_r, pfx_repe_nxt;
  reg fault_nxt;
  reg op_done;
  reg [9:0] info_v;

  wire take = i_byte_valid & ready_r;
  wire opsz32 = ctrl_r[`IFD_CTRL_OP32_BIT] ^ pfx_opsz_r;
  wire ad32 = ctrl_r[`IFD_CTRL_AD32_BIT] ^ pfx_adsz_r;
  wire need_sib = ad32 && i_byte_data[7:6] != 2'h3 && i_byte_data[2:0] == 3'h4;

  always @* begin
    state_nxt = state_r;
    len_nxt = len_r;
    tail_nxt = tail_r;
    imm_nxt = imm_r;
    opcode_nxt = opcode_r;
    two_nxt = two_r;
    modrm_nxt = modrm_r;
    sib_nxt = sib_r;
    has_sib_nxt = has_sib_r;
    pfx_seg_nxt = pfx_seg_r;
    pfx_ov_nxt = pfx_ov_r;
    pfx_opsz_nxt = pfx_opsz_r;
    pfx_adsz_nxt = pfx_adsz_r;
    pfx_lock_nxt = pfx_lock_r;
    pfx_repeat_while_unequal_prefix_nxt = pfx_repeat_while_unequal_prefix_r;
    pfx_repe_nxt = pfx_repe_r;
    fault_nxt = 1'b0;
    op_done = 1'b0;
    info_v = 10'h000;
    if (state_r == ST_EMIT) begin
      // one instruction is done: no prefix survives into the next one
      state_nxt = ST_PFX;
      len_nxt = 5'h00;
      pfx_ov_nxt = 1'b0;
      pfx_opsz_nxt = 1'b0;
      pfx_adsz_nxt = 1'b0;
      pfx_lock_nxt = 1'b0;
      pfx_repeat_while_unequal_prefix_nxt = 1'b0;
      pfx_repe_nxt = 1'b0;
    end else if (take && len_r == `IFD_MAX_LEN) begin
      // a sixteenth byte: drop the instruction, fetch must restart
      fault_nxt = 1'b1;
      state_nxt = ST_PFX;
      len_nxt = 5'h00;
      pfx_ov_nxt = 1'b0;
      pfx_opsz_nxt = 1'b0;
      pfx_adsz_nxt = 1'b0;
      pfx_lock_nxt = 1'b0;
      pfx_repeat_while_unequal_prefix_nxt = 1'b0;
      pfx_repe_nxt = 1'b0;
    end else if (take) begin
      len_nxt = len_r + 5'h01;
      case (state_r)
        ST_PFX: begin
          // prefixes set flags in any order, except that of several segment prefixes the last one wins
          case (i_byte_data)
            `IFD_PFX_ES, `IFD_PFX_CS, `IFD_PFX_SS, `IFD_PFX_DS: begin
              pfx_seg_nxt = {1'b0, i_byte_data[4:3]};
              pfx_ov_nxt = 1'b1;
            end
            `IFD_PFX_FS, `IFD_PFX_GS: begin
              pfx_seg_nxt = {2'h2, i_byte_data[0]};
              pfx_ov_nxt = 1'b1;
            end
            `IFD_PFX_OPSZ: pfx_opsz_nxt = 1'b1;
            `IFD_PFX_ADSZ: pfx_adsz_nxt = 1'b1;
            `IFD_PFX_LOCK: pfx_lock_nxt = 1'b1;
            `IFD_PFX_REPEAT_WHILE_UNEQUAL_PREFIX: pfx_repeat_while_unequal_prefix_nxt = 1'b1;
            `IFD_PFX_REPE: pfx_repe_nxt = 1'b1;
            `IFD_ESCAPE: state_nxt = ST_OP2;
            default: op_done = 1'b1;
          endcase
        end
        ST_OP2: op_done = 1'b1;
        ST_MODRM: begin
          modrm_nxt = i_byte_data;
          if (need_sib) begin
            has_sib_nxt = 1'b1;
            state_nxt = ST_SIB;
          end else begin
            tail_nxt = disp_bytes(ad32, i_byte_data, 3'h0) + imm_r;
            state_nxt = (tail_nxt == 4'h0) ? ST_EMIT : ST_TAIL;
          end
        end
        ST_SIB: begin
          sib_nxt = i_byte_data;
          tail_nxt = disp_bytes(ad32, modrm_r, i_byte_data[2:0]) + imm_r;
          state_nxt = (tail_nxt == 4'h0) ? ST_EMIT : ST_TAIL;
        end
        ST_TAIL: begin
          tail_nxt = tail_r - 4'h1;
          if (tail_r == 4'h1)
            state_nxt = ST_EMIT;
        end
        default: state_nxt = ST_PFX;
      endcase
      if (op_done) begin
        // the mod r/m byte, when present, may still refine the opcode
        two_nxt = (state_r == ST_OP2);
        opcode_nxt = i_byte_data;
        info_v = op_info(two_nxt, i_byte_data);
        imm_nxt = imm_bytes(info_v, opsz32);
        has_sib_nxt = 1'b0;
        modrm_nxt = 8'h00;
        sib_nxt = 8'h00;
        tail_nxt = imm_nxt;
        if (info_v[0])
          state_nxt = ST_MODRM;
        else
          state_nxt = (imm_nxt == 4'h0) ? ST_EMIT : ST_TAIL;
      end
    end
  end

  // field decode of the finished instruction
  reg [9:0] inf_e;
  reg byte_e;
  reg [1:0] opsz_e;
  reg [3:0] base_e, index_e;
  reg [1:0] scale_e;
  reg ss_e;
  reg mem_e;
  reg [2:0] seg_e;
  reg [1:0] spk_e;
  reg spv_e;
  reg [3:0] disp_e;
  wire [1:0] mod_w = modrm_r[7:6];
  wire [2:0] rm_w = modrm_r[2:0];
  wire [2:0] eee_w = modrm_r[5:3];

  always @* begin
    inf_e = op_info(two_r, opcode_r);
    byte_e = inf_e[2] & ~inf_e[3];
    opsz_e = byte_e ? `IFD_OPSZ_8 : (opsz32 ? `IFD_OPSZ_32 : `IFD_OPSZ_16);
    mem_e = inf_e[0] && mod_w != 2'h3;
    base_e = 4'h0;
    index_e = 4'h0;
    scale_e = 2'h0;
    ss_e = 1'b0;
    if (!ad32) begin
      case (rm_w)
        3'h0: begin base_e = {1'b1, `IFD_REG_BX}; index_e = {1'b1, `IFD_REG_SI}; end
        3'h1: begin base_e = {1'b1, `IFD_REG_BX}; index_e = {1'b1, `IFD_REG_DI}; end
        3'h2: begin base_e = {1'b1, `IFD_REG_BP}; index_e = {1'b1, `IFD_REG_SI}; end
        3'h3: begin base_e = {1'b1, `IFD_REG_BP}; index_e = {1'b1, `IFD_REG_DI}; end
        3'h4: index_e = {1'b1, `IFD_REG_SI};
        3'h5: index_e = {1'b1, `IFD_REG_DI};
        3'h6: if (mod_w != 2'h0) base_e = {1'b1, `IFD_REG_BP};
        default: base_e = {1'b1, `IFD_REG_BX};
      endcase
      ss_e = (base_e == {1'b1, `IFD_REG_BP});
    end else if (!has_sib_r) begin
      if (!(mod_w == 2'h0 && rm_w == 3'h5))
        base_e = {1'b1, rm_w};
      ss_e = (base_e == {1'b1, `IFD_REG_BP});
    end else begin
      if (!(mod_w == 2'h0 && sib_r[2:0] == 3'h5))
        base_e = {1'b1, sib_r[2:0]};
      if (sib_r[5:3] != `IFD_REG_SP)
        index_e = {1'b1, sib_r[5:3]};
      // 10 is taken as the x4 pattern, so the field is a shift count
      scale_e = sib_r[7:6];
      ss_e = (base_e == {1'b1, `IFD_REG_SP}) || (base_e == {1'b1, `IFD_REG_BP});
    end
    seg_e = pfx_ov_r ? pfx_seg_r : (ss_e ? `IFD_SEG_SS : `IFD_SEG_DS);
    // never above four bytes, so the top bit is always clear
    disp_e = disp_bytes(ad32, modrm_r, sib_r[2:0]);
    // special moves: 0F 20/22 control, 21/23 debug, 24/26 test
    spk_e = opcode_r[2] ? 2'h2 : {1'b0, opcode_r[0]};
    case (spk_e)
      2'h0: spv_e = (eee_w == 3'h0) || (eee_w >= 3'h2 && eee_w <= 3'h4);
      2'h1: spv_e = (eee_w <= 3'h3) || (eee_w >= 3'h6);
      default: spv_e = (eee_w >= 3'h3);
    endcase
  end

  // output registers
  reg lock_r, valid_r, fault_r, two_o_r, ad32_r, dir_r, rmreg_r, mem_r, sext_r;
  reg repeat_while_unequal_prefix_r, repe_r, sregv_r, specv_r;
  reg [3:0] len_o_r, reg_r, rm_r, base_r, index_r;
  reg [7:0] opcode_o_r;
  reg [2:0] group_r, seg_r, disp_r, imm_o_r, sreg_r, spsel_r;
  reg [1:0] opsz_r, scale_r, spk_r;

  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_r <= ST_PFX;
      ready_r <= 1'b0;
      len_r <= 5'h00;
      tail_r <= 4'h0;
      imm_r <= 4'h0;
      opcode_r <= 8'h00;
      two_r <= 1'b0;
      modrm_r <= 8'h00;
      sib_r <= 8'h00;
      has_sib_r <= 1'b0;
      pfx_seg_r <= `IFD_SEG_DS;
      pfx_ov_r <= 1'b0;
      pfx_opsz_r <= 1'b0;
      pfx_adsz_r <= 1'b0;
      pfx_lock_r <= 1'b0;
      pfx_repeat_while_unequal_prefix_r <= 1'b0;
      pfx_repe_r <= 1'b0;
      lock_r <= 1'b0;
      valid_r <= 1'b0;
      fault_r <= 1'b0;
      len_o_r <= 4'h0;
      opcode_o_r <= 8'h00;
      two_o_r <= 1'b0;
      group_r <= 3'h0;
      opsz_r <= `IFD_OPSZ_8;
      ad32_r <= 1'b0;
      dir_r <= 1'b0;
      reg_r <= 4'h0;
      rmreg_r <= 1'b0;
      rm_r <= 4'h0;
      mem_r <= 1'b0;
      base_r <= 4'h0;
      index_r <= 4'h0;
      scale_r <= 2'h0;
      seg_r <= `IFD_SEG_DS;
      disp_r <= 3'h0;
      imm_o_r <= 3'h0;
      sext_r <= 1'b0;
      repeat_while_unequal_prefix_r <= 1'b0;
      repe_r <= 1'b0;
      sreg_r <= 3'h0;
      sregv_r <= 1'b0;
      spk_r <= 2'h0;
      spsel_r <= 3'h0;
      specv_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ready_r <= (state_nxt != ST_EMIT);
      len_r <= len_nxt;
      tail_r <= tail_nxt;
      imm_r <= imm_nxt;
      opcode_r <= opcode_nxt;
      two_r <= two_nxt;
      modrm_r <= modrm_nxt;
      sib_r <= sib_nxt;
      has_sib_r <= has_sib_nxt;
      pfx_seg_r <= pfx_seg_nxt;
      pfx_ov_r <= pfx_ov_nxt;
      pfx_opsz_r <= pfx_opsz_nxt;
      pfx_adsz_r <= pfx_adsz_nxt;
      pfx_lock_r <= pfx_lock_nxt;
      pfx_repeat_while_unequal_prefix_r <= pfx_repeat_while_unequal_prefix_nxt;
      pfx_repe_r <= pfx_repe_nxt;
      valid_r <= (state_r == ST_EMIT);
      fault_r <= fault_nxt;
      // a new locked instruction wins over the release of the previous one
      if (state_r == ST_EMIT && pfx_lock_r)
        lock_r <= 1'b1;
      else if (i_exec_done)
        lock_r <= 1'b0;
      if (state_r == ST_EMIT) begin
        len_o_r <= len_r[3:0];
        opcode_o_r <= opcode_r;
        two_o_r <= two_r;
        group_r <= eee_w;
        opsz_r <= opsz_e;
        ad32_r <= ad32;
        dir_r <= inf_e[4] & opcode_r[1];
        reg_r <= {byte_e, eee_w};
        rmreg_r <= inf_e[0] && mod_w == 2'h3;
        rm_r <= {byte_e, rm_w};
        mem_r <= mem_e;
        base_r <= mem_e ? base_e : 4'h0;
        index_r <= mem_e ? index_e : 4'h0;
        scale_r <= mem_e ? scale_e : 2'h0;
        seg_r <= seg_e;
        disp_r <= mem_e ? disp_e[2:0] : 3'h0;
        imm_o_r <= imm_r[2:0];
        sext_r <= inf_e[1] & inf_e[5] & ~byte_e;
        repeat_while_unequal_prefix_r <= pfx_repeat_while_unequal_prefix_r & inf_e[6];
        repe_r <= pfx_repe_r & inf_e[6];
        sreg_r <= inf_e[7] ? {1'b0, opcode_r[4:3]} : eee_w;
        sregv_r <= inf_e[7] | (inf_e[8] & (eee_w <= `IFD_SEG_GS));
        spk_r <= spk_e;
        spsel_r <= eee_w;
        specv_r <= inf_e[9] & spv_e;
      end
    end
  end

  // avalon slave: one wait cycle, answer on the cycle after the request
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ctrl_r <= `IFD_CTRL_RESET;
      instr_cnt_r <= 16'h0000;
      fault_cnt_r <= 8'h00;
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      wait_r <= ~((i_avs_read | i_avs_write) & wait_r);
      if (state_r == ST_EMIT)
        instr_cnt_r <= instr_cnt_r + 16'h0001;
      if (fault_nxt)
        fault_cnt_r <= fault_cnt_r + 8'h01;
      if (i_avs_write && !wait_r && i_avs_address == `IFD_CTRL_OFS && i_avs_byteenable[0])
        ctrl_r <= i_avs_writedata[1:0];
      if (i_avs_read && wait_r) begin
        case (i_avs_address)
          `IFD_CTRL_OFS: rdata_r <= {30'h0, ctrl_r};
          `IFD_STATUS_OFS: rdata_r <= {7'h00, lock_r, fault_cnt_r, instr_cnt_r};
          `IFD_LAST_OFS: rdata_r <= {11'h000, seg_r, ad32_r, opsz_r, len_o_r, two_o_r,
                                     2'h0, opcode_o_r};
          default: rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign o_byte_ready = ready_r;
  assign o_bus_lock = lock_r;
  assign o_dec_valid = valid_r;
  assign o_gp_fault = fault_r;
  assign o_dec_len = len_o_r;
  assign o_opcode = opcode_o_r;
  assign o_two_byte = two_o_r;
  assign o_group_sel = group_r;
  assign o_op_size = opsz_r;
  assign o_addr32 = ad32_r;
  assign o_dir = dir_r;
  assign o_reg_sel = reg_r;
  assign o_rm_is_reg = rmreg_r;
  assign o_rm_sel = rm_r;
  assign o_mem_operand = mem_r;
  assign o_base_sel = base_r;
  assign o_index_sel = index_r;
  assign o_scale = scale_r;
  assign o_seg = seg_r;
  assign o_disp_size = disp_r;
  assign o_imm_size = imm_o_r;
  assign o_imm_sext = sext_r;
  assign o_repeat_while_unequal_prefix = repeat_while_unequal_prefix_r;
  assign o_repeat_while_equal_prefix = repe_r;
  assign o_sreg_sel = sreg_r;
  assign o_sreg_valid = sregv_r;
  assign o_special_kind = spk_r;
  assign o_special_sel = spsel_r;
  assign o_special_valid = specv_r;
  assign o_avs_readdata = rdata_r;
  assign o_avs_waitrequest = wait_r;

endmodule // instruction_field_decoder
`default_nettype wire

// *** instruction_field_decoder_defines.vh ***
/*
  constants for the instruction field decoder: register offsets, control bits,
  reset values, prefix encodings, segment and size codes, length limit.
  assumes it is included by its bare name from the decoder source.
*/
`ifndef INSTRUCTION_FIELD_DECODER_DEFINES_VH
`define INSTRUCTION_FIELD_DECODER_DEFINES_VH

// register byte offsets
`define IFD_CTRL_OFS 4'h0
`define IFD_STATUS_OFS 4'h4
`define IFD_LAST_OFS 4'h8

// control register bits and reset value
`define IFD_CTRL_OP32_BIT 0
`define IFD_CTRL_AD32_BIT 1
`define IFD_CTRL_RESET 2'h0

// prefix bytes
`define IFD_PFX_ES 8'h26
`define IFD_PFX_CS 8'h2E
`define IFD_PFX_SS 8'h36
`define IFD_PFX_DS 8'h3E
`define IFD_PFX_FS 8'h64
`define IFD_PFX_GS 8'h65
`define IFD_PFX_OPSZ 8'h66
`define IFD_PFX_ADSZ 8'h67
`define IFD_PFX_LOCK 8'hF0
`define IFD_PFX_REPEAT_WHILE_UNEQUAL_PREFIX 8'hF2
`define IFD_PFX_REPE 8'hF3
`define IFD_ESCAPE 8'h0F

// segment codes, same as the 3-bit segment select field
`define IFD_SEG_ES 3'h0
`define IFD_SEG_CS 3'h1
`define IFD_SEG_SS 3'h2
`define IFD_SEG_DS 3'h3
`define IFD_SEG_FS 3'h4
`define IFD_SEG_GS 3'h5

// operand size codes
`define IFD_OPSZ_8 2'h0
`define IFD_OPSZ_16 2'h1
`define IFD_OPSZ_32 2'h2

// register codes used by addressing
`define IFD_REG_BX 3'h3
`define IFD_REG_SP 3'h4
`define IFD_REG_BP 3'h5
`define IFD_REG_SI 3'h6
`define IFD_REG_DI 3'h7

// longest legal instruction in bytes
`define IFD_MAX_LEN 5'h0F

`endif

// *** instruction_field_decoder_properties.sv ***
/*
  checker for the instruction field decoder, bound to its ports.
  assumes one core clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ifd_properties (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // watched ports
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic o_byte_ready,
  input wire logic i_exec_done,
  input wire logic o_bus_lock,
  input wire logic o_dec_valid,
  input wire logic o_gp_fault,
  input wire logic [3:0] o_dec_len,
  input wire logic [2:0] o_seg,
  input wire logic o_special_valid,
  input wire logic [1:0] o_special_kind,
  input wire logic [2:0] o_special_sel,
  input wire logic o_imm_sext,
  input wire logic [2:0] o_imm_size
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  dec_pulse_a: assert property (o_dec_valid |=> !o_dec_valid) else $error("valid too long");
  emit_gap_a: assert property (!o_byte_ready && $past(i_rst_n) |=> o_dec_valid)
    else $error("ready low without emit");
  len_range_a: assert property (o_dec_valid |-> o_dec_len != 4'h0) else $error("bad len");
  fault_alone_a: assert property (o_gp_fault |-> !o_dec_valid) else $error("fault with valid");
  lock_hold_a: assert property (o_bus_lock && !i_exec_done |=> o_bus_lock)
    else $error("lock dropped");
  lock_clear_a: assert property (i_exec_done ##1 !o_dec_valid |-> !o_bus_lock)
    else $error("lock stuck");
  seg_code_a: assert property (o_dec_valid |-> o_seg <= 3'h5) else $error("bad seg");
  cr_code_a: assert property (o_special_valid && o_special_kind == 2'h0
    |-> o_special_sel inside {3'h0, 3'h2, 3'h3, 3'h4}) else $error("bad cr");
  dr_tr_code_a: assert property (o_special_valid && o_special_kind != 2'h0
    |-> o_special_sel >= (o_special_kind == 2'h1 ? 3'h6 : 3'h3) || o_special_kind == 2'h1
    && o_special_sel <= 3'h3) else $error("bad dr tr");
  imm_narrow_a: assert property (o_dec_valid && o_imm_sext |-> o_imm_size == 3'h1)
    else $error("bad sext size");
  bus_wait_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest ##1 o_avs_waitrequest) else $error("bad wait state");
endmodule // ifd_properties
bind instruction_field_decoder ifd_properties u_props (.i_core_clk(i_core_clk),
  .i_rst_n(i_rst_n), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_waitrequest(o_avs_waitrequest), .o_byte_ready(o_byte_ready),
  .i_exec_done(i_exec_done), .o_bus_lock(o_bus_lock), .o_dec_valid(o_dec_valid),
  .o_gp_fault(o_gp_fault), .o_dec_len(o_dec_len), .o_seg(o_seg),
  .o_special_valid(o_special_valid), .o_special_kind(o_special_kind),
  .o_special_sel(o_special_sel), .o_imm_sext(o_imm_sext), .o_imm_size(o_imm_size));
`default_nettype wire

// *** tb_instruction_field_decoder.sv ***
/*
  self-checking bench for the instruction field decoder.
  assumes the defines header is on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "instruction_field_decoder_defines.vh"
module tb_instruction_field_decoder;
  logic clk = 0, rst_n = 0, bv = 0, ed = 0, rd = 0, wr = 0;
  logic [7:0] bd = 8'h00;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, q;
  wire br, bl, dv, gf, tb2, a32, dir, rr, sv, spv, ru, re, wq, sx;
  wire [3:0] ln, rs, rm, bs, ix;
  wire [2:0] gs, sg, ds, ims, ssl, sps;
  wire [1:0] os, sc, sk;
  wire [31:0] ard;
  wire mo;
  wire [7:0] opc;
  int num_errors = 0, checks = 0;
  always #50 clk = ~clk;
  instruction_field_decoder dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_byte_valid(bv),
    .i_byte_data(bd), .o_byte_ready(br), .i_exec_done(ed), .o_bus_lock(bl),
    .o_dec_valid(dv), .o_gp_fault(gf), .o_dec_len(ln), .o_opcode(opc), .o_two_byte(tb2),
    .o_group_sel(gs), .o_op_size(os), .o_addr32(a32), .o_dir(dir), .o_reg_sel(rs),
    .o_rm_is_reg(rr), .o_rm_sel(rm), .o_mem_operand(mo), .o_base_sel(bs), .o_index_sel(ix),
    .o_scale(sc), .o_seg(sg), .o_disp_size(ds), .o_imm_size(ims), .o_imm_sext(sx),
    .o_repeat_while_unequal_prefix(ru), .o_repeat_while_equal_prefix(re),
    .o_sreg_sel(ssl), .o_sreg_valid(sv), .o_special_kind(sk), .o_special_sel(sps),
    .o_special_valid(spv), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(ard),
    .o_avs_waitrequest(wq));
  task chk(input string n, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %0h got %0h", n, e, g);
    end
  endtask
  task p(input logic [7:0] b);
    bv <= 1'b1;
    bd <= b;
    for (int k = 0; k < 9; k++) begin
      @(negedge clk);
      if (br === 1'b1) break;
    end
    @(posedge clk);
  endtask
  // drop valid, then wait for the one-cycle decode pulse
  task ins(input logic [7:0] b [$]);
    foreach (b[i]) p(b[i]);
    bv <= 1'b0;
    for (int k = 0; k < 9; k++) begin
      @(negedge clk);
      if (dv === 1'b1) break;
    end
    chk("dv", 1, dv);
    @(posedge clk);
  endtask
  // hold the request until waitrequest is sampled low at a rising edge
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wq !== 1'b0 && k < 9);
    if (wq !== 1'b0) num_errors++;
    q = ard;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task t_reset;
    chk("wait", 1, wq);
    bus(0, `IFD_CTRL_OFS, 32'h0);
    chk("ctrl", `IFD_CTRL_RESET, q);
    bus(0, 4'hC, 32'h0);
    chk("unmapped", 0, q);
  endtask
  task t_size;
    ins('{8'h66, 8'h01, 8'hC8});
    chk("os", `IFD_OPSZ_32, os);
    chk("rr", 1, rr);
    chk("mo", 0, mo);
    chk("dir", 0, dir);
    chk("rs", 4'h1, rs);
    chk("len", 4'h3, ln);
    ins('{8'h01, 8'hC8});
    chk("os", `IFD_OPSZ_16, os);
    bus(1, `IFD_CTRL_OFS, 32'h1);
    ins('{8'h88, 8'hC4});
    chk("os", `IFD_OPSZ_8, os);
    chk("rs", 4'h8, rs);
    chk("rm", 4'hC, rm);
    ins('{8'h01, 8'hC8});
    chk("os", `IFD_OPSZ_32, os);
    bus(1, `IFD_CTRL_OFS, 32'h0);
  endtask
  task t_seg;
    ins('{8'h26, 8'h2E, 8'h36, 8'h3E, 8'h64, 8'h65, 8'h8B, 8'h07});
    chk("sg", `IFD_SEG_GS, sg);
    chk("bs", 4'hB, bs);
    chk("mo", 1, mo);
    for (int o = 0; o < 2; o++) begin
      ins('{o ? 8'h66 : 8'h26, o ? 8'h26 : 8'h66, 8'h03, 8'h46, 8'h05});
      chk("sg", `IFD_SEG_ES, sg);
      chk("os", `IFD_OPSZ_32, os);
      chk("dir", 1, dir);
    end
    ins('{8'h03, 8'h46, 8'h05});
    chk("sg", `IFD_SEG_SS, sg);
    chk("ds", 1, ds);
    chk("bs", 4'hD, bs);
  endtask
  task t_sib;
    ins('{8'h67, 8'h8B, 8'h04, 8'h8D, 8'h00, 8'h10, 8'h00, 8'h00});
    chk("a32", 1, a32);
    chk("ix", 4'h9, ix);
    chk("sc", 2'h2, sc);
    chk("bs", 0, bs);
    chk("ds", 4, ds);
    chk("len", 4'h8, ln);
    ins('{8'h67, 8'h8B, 8'h44, 8'h24, 8'h08});
    chk("bs", 4'hC, bs);
    chk("ix", 0, ix);
    chk("sg", `IFD_SEG_SS, sg);
  endtask
  task t_imm;
    ins('{8'h83, 8'hC0, 8'h05});
    chk("ims", 1, ims);
    chk("sx", 1, sx);
    chk("op", 8'h83, opc);
    ins('{8'h81, 8'hC0, 8'h34, 8'h12});
    chk("ims", 2, ims);
    ins('{8'h80, 8'hF8, 8'h01});
    chk("gs", 3'h7, gs);
    chk("ims", 1, ims);
    bus(0, `IFD_LAST_OFS, 32'h0);
    chk("last", {11'h000, `IFD_SEG_DS, 1'b0, `IFD_OPSZ_8, 4'h3, 3'h0, 8'h80}, q);
  endtask
  task t_lock_rep;
    ins('{8'hF0, 8'h01, 8'hC8});
    repeat (3) @(negedge clk);
    chk("lock", 1, bl);
    @(posedge clk);
    ed <= 1'b1;
    @(posedge clk);
    ed <= 1'b0;
    @(negedge clk);
    chk("lock", 0, bl);
    @(posedge clk);
    ins('{8'hF3, 8'hA4});
    chk("re", 1, re);
    ins('{8'hF2, 8'hA6});
    chk("ru", 1, ru);
    ins('{8'hF3, 8'h01, 8'hC8});
    chk("re", 0, re);
  endtask
  task t_special;
    logic [7:0] o2 [6] = '{8'h22, 8'h22, 8'h23, 8'h23, 8'h26, 8'h26};
    logic [7:0] mr [6] = '{8'hD8, 8'hC8, 8'hF8, 8'hE0, 8'hD8, 8'hC0};
    for (int i = 0; i < 6; i++) begin
      ins('{8'h0F, o2[i], mr[i]});
      chk("tb2", 1, tb2);
      chk("spv", !i[0], spv);
      if (!i[0]) chk("sk", i / 2, sk);
      if (!i[0]) chk("sps", mr[i][5:3], sps);
    end
    ins('{8'h8E, 8'hD8});
    chk("ssl", 3, ssl);
    ins('{8'h8E, 8'hF0});
    chk("sv", 0, sv);
    ins('{8'h1E});
    chk("ssl", 3, ssl);
    chk("sv", 1, sv);
  endtask
  task t_len;
    ins('{8'h66, 8'h66, 8'h66, 8'h66, 8'h66, 8'h66, 8'h66, 8'h66, 8'h66, 8'h66, 8'h66,
      8'h66, 8'h66, 8'h66, 8'h90});
    chk("len", 4'hF, ln);
    repeat (16) p(`IFD_PFX_ES);
    bv <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      @(negedge clk);
      if (gf === 1'b1) break;
    end
    chk("gf", 1, gf);
    @(posedge clk);
    ins('{8'h8B, 8'h07});
    chk("sg", `IFD_SEG_DS, sg);
  endtask
  task close_out;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_size;
    t_seg;
    t_sib;
    t_imm;
    t_lock_rep;
    t_special;
    t_len;
    close_out;
  end
  initial begin
    #(4000 * 100);
    num_errors++;
    close_out;
  end
endmodule // tb_instruction_field_decoder
`default_nettype wire
